/* tcrb_params.svh */
// Constants shared by the tuner register bank, its host and the link.
// Assumes inclusion by bare name; definitions only.
`ifndef TCRB_PARAMS_SVH
`define TCRB_PARAMS_SVH
// ****************************************
// Device register map
// ****************************************
`define TCRB_ADDR_N_HIGH   4'h0
`define TCRB_ADDR_R_DIV    4'h2
`define TCRB_ADDR_TF_PAR   4'h8
`define TCRB_ADDR_TF_ROM   4'h9
`define TCRB_ADDR_RSVD     4'hA
`define TCRB_ADDR_ROM_RD   4'hB
`define TCRB_ADDR_STATUS   4'hC
`define TCRB_LAST_PROG     4'h9
`define TCRB_NUM_PROG      11
`define TCRB_RESET_BYTE    8'h00
`define TCRB_FLD_BIT       7
`define TCRB_HIGH7         6
`define TCRB_ROM_IDX_MSB   3
`define TCRB_BYTE_BITS     4'h8
// Fixed-zero bits of registers 0x0A down to 0x00, one byte each
`define TCRB_ZERO_MASKS    88'h00F0400007F08000800080
`define TCRB_N_HIGH_MIN    7'h01
`define TCRB_R_MIN         7'h10
`define TCRB_I2C_BASE      5'h18
`define TCRB_ROM_DEFAULT   128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0
// ****************************************
// Controller registers on AXI4-Lite
// ****************************************
`define TCRB_OFS_CMD       8'h00
`define TCRB_OFS_STATUS    8'h04
`define TCRB_OFS_IRQ_STAT  8'h08
`define TCRB_OFS_IRQ_EN    8'h0C
`define TCRB_OFS_IRQ_CLR   8'h10
`define TCRB_CMD_REG_LSB   8
`define TCRB_CMD_READ_BIT  16
`define TCRB_CMD_ID_LSB    20
`define TCRB_RESP_OKAY     2'h0
`define TCRB_RESP_SLVERR   2'h2
`define TCRB_IRQ_W         3
// ****************************************
// Timing
// ****************************************
`define TCRB_CLK_NS        40
`define TCRB_POWERUP_NS    100000
`define TCRB_SCL_PERIOD_NS 2500
`endif

/* tcrb_pkg.sv */
// Types shared by both ends of the tuner register bank link.
// Assumes nothing beyond a SystemVerilog compiler.
package tcrb_pkg;
	typedef enum logic [2:0] {
		DEV_IDLE = 3'b000,
		DEV_ADDR = 3'b001,
		DEV_PTR  = 3'b010,
		DEV_WDAT = 3'b011,
		DEV_RDAT = 3'b100
	} tcrb_dev_state_type;
	typedef enum logic [2:0] {
		HOST_IDLE   = 3'b000,
		HOST_START  = 3'b001,
		HOST_BIT    = 3'b010,
		HOST_RSTART = 3'b011,
		HOST_STOP   = 3'b100
	} tcrb_host_state_type;
endpackage : tcrb_pkg

/* tcrb_link_if.sv */
// Two-wire serial link between host controller and register bank.
// Assumes pull-ups: a wire is low while any party enables its driver.
`timescale 1ns/100ps
interface tcrb_link_if;
	logic scl_oe_host;
	logic sda_oe_host;
	logic sda_oe_dev;
	logic scl;
	logic sda;
	assign scl = ~scl_oe_host;
	assign sda = ~(sda_oe_host | sda_oe_dev);
	modport host (output scl_oe_host, output sda_oe_host, input sda);
	modport dev  (output sda_oe_dev, input scl, input sda);
endinterface : tcrb_link_if

/* tcrb_device.sv */
// Tuner control register bank: serial slave with thirteen byte registers.
// Assumes host keeps SCL low and high for several clk cycles each.
`timescale 1ns/100ps
`include "tcrb_params.svh"
module tcrb_device
	import tcrb_pkg::*;
#(
	parameter logic [4:0]   BASE_ADDR = `TCRB_I2C_BASE,
	parameter logic [127:0] ROM_TABLE = `TCRB_ROM_DEFAULT
) (
	input  wire logic          clk,
	input  wire logic          rst,
	tcrb_link_if.dev           link,
	input  wire logic          bus_id_select_a,
	input  wire logic          bus_id_select_b,
	input  wire logic [2:0]    lock_indication,
	output logic [14:0]        feedback_divider,
	output logic [6:0]         reference_divider,
	output logic [87:0]        reg_image,
	output logic [7:0]         rom_table_readback
);
	// ****************************************
	// Declarations
	// ****************************************
	localparam int SYNC_W = 7;
	logic [SYNC_W-1:0]  sync1;
	logic [SYNC_W-1:0]  sync2;
	logic               scl_s;
	logic               sda_s;
	logic               scl_p;
	logic               sda_p;
	logic               scl_rise;
	logic               scl_fall;
	logic               start_seen;
	logic               stop_seen;
	logic [6:0]         dev_addr;
	tcrb_dev_state_type state;
	logic               ack_ph;
	logic [3:0]         bit_cnt;
	logic [7:0]         shreg;
	logic [7:0]         tx;
	logic [3:0]         ptr;
	logic               host_nack;
	logic               sda_drv;
	logic               byte_done;
	logic               wr_fire;
	logic               rd_load;
	logic               fld_rise;
	logic               por;
	logic [7:0]         rd_now;
	logic [7:0]         regs [0:`TCRB_NUM_PROG-1];

	// ****************************************
	// Read multiplexer
	// ****************************************
	function automatic logic [7:0] rd_byte(input logic [3:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a <= `TCRB_ADDR_RSVD) begin
			v = regs[a];
		end else if (a == `TCRB_ADDR_ROM_RD) begin
			v = rom_table_readback;
		end else if (a == `TCRB_ADDR_STATUS) begin
			v = {por, sync2[2:0], 4'h0};
		end
		return v;
	endfunction : rd_byte

	// ****************************************
	// Input synchronisers and edge detection
	// ****************************************
	always_ff @(posedge clk) begin
		sync1 <= {link.scl, link.sda, bus_id_select_b, bus_id_select_a, lock_indication};
		sync2 <= sync1;
	end

	assign scl_s = sync2[6];
	assign sda_s = sync2[5];

	always_ff @(posedge clk) begin
		if (rst) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_p <= scl_s;
			sda_p <= sda_s;
		end
	end

	assign scl_rise   = scl_s & ~scl_p;
	assign scl_fall   = ~scl_s & scl_p;
	assign start_seen = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_seen  = scl_s & scl_p & ~sda_p & sda_s;
	// Pins may move at any time; both pins are read together
	assign dev_addr   = {BASE_ADDR, sync2[4], sync2[3]};
	assign byte_done  = scl_fall & ~ack_ph & (bit_cnt == `TCRB_BYTE_BITS);
	assign wr_fire    = byte_done & (state == DEV_WDAT);
	assign rd_load    = scl_fall & ack_ph & (state == DEV_RDAT) & ~host_nack;
	assign rd_now     = rd_byte(ptr);

	// ****************************************
	// Serial protocol engine
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			state     <= DEV_IDLE;
			ack_ph    <= 1'b0;
			bit_cnt   <= 4'h0;
			shreg     <= 8'h00;
			tx        <= 8'h00;
			ptr       <= 4'h0;
			host_nack <= 1'b0;
			sda_drv   <= 1'b0;
		end else if (stop_seen) begin
			state   <= DEV_IDLE;
			ack_ph  <= 1'b0;
			sda_drv <= 1'b0;
		end else if (start_seen) begin
			state   <= DEV_ADDR;
			ack_ph  <= 1'b0;
			bit_cnt <= 4'h0;
			sda_drv <= 1'b0;
		end else if (scl_rise && state != DEV_IDLE) begin
			if (ack_ph) begin
				host_nack <= sda_s;
			end else begin
				shreg   <= {shreg[6:0], sda_s};
				bit_cnt <= 4'(bit_cnt + 4'h1);
			end
		end else if (scl_fall && state != DEV_IDLE) begin
			if (ack_ph) begin
				ack_ph  <= 1'b0;
				bit_cnt <= 4'h0;
				if (rd_load) begin
					tx      <= rd_now;
					ptr     <= 4'(ptr + 4'h1);
					sda_drv <= ~rd_now[7];
				end else begin
					sda_drv <= 1'b0;
					if (state == DEV_RDAT) begin
						state <= DEV_IDLE;
					end
				end
			end else if (byte_done) begin
				ack_ph <= 1'b1;
				unique case (state)
					DEV_ADDR: begin
						if (shreg[7:1] == dev_addr) begin
							sda_drv <= 1'b1;
							state   <= shreg[0] ? DEV_RDAT : DEV_PTR;
						end else begin
							state <= DEV_IDLE;
						end
					end
					DEV_PTR: begin
						ptr     <= shreg[3:0];
						sda_drv <= 1'b1;
						state   <= DEV_WDAT;
					end
					DEV_WDAT: begin
						ptr     <= 4'(ptr + 4'h1);
						sda_drv <= 1'b1;
					end
					DEV_RDAT: begin
						sda_drv <= 1'b0;
					end
					default: begin
						state <= DEV_IDLE;
					end
				endcase
			end else if (state == DEV_RDAT) begin
				tx      <= {tx[6:0], 1'b0};
				sda_drv <= ~tx[6];
			end
		end
	end

	assign link.sda_oe_dev = sda_drv;

	// ****************************************
	// Programmable registers
	// ****************************************
	// Contents are not guaranteed at power-up; zero is simply a known value
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < `TCRB_NUM_PROG; i++) begin
				regs[i] <= `TCRB_RESET_BYTE;
			end
		end else if (wr_fire && ptr <= `TCRB_ADDR_RSVD) begin
			regs[ptr] <= shreg;
		end
	end

	assign feedback_divider  = {regs[`TCRB_ADDR_N_HIGH][`TCRB_HIGH7:0],
		regs[`TCRB_ADDR_N_HIGH + 4'h1]};
	assign reference_divider = regs[`TCRB_ADDR_R_DIV][`TCRB_HIGH7:0];

	for (genvar g = 0; g < `TCRB_NUM_PROG; g++) begin : g_image
		assign reg_image[g*8 +: 8] = regs[g];
	end

	// ****************************************
	// ROM readback and status
	// ****************************************
	assign fld_rise = wr_fire & (ptr == `TCRB_ADDR_TF_PAR) & shreg[`TCRB_FLD_BIT]
		& ~regs[`TCRB_ADDR_TF_PAR][`TCRB_FLD_BIT];

	always_ff @(posedge clk) begin
		if (rst) begin
			rom_table_readback <= 8'h00;
		end else if (fld_rise) begin
			rom_table_readback <= ROM_TABLE[{regs[`TCRB_ADDR_TF_ROM][`TCRB_ROM_IDX_MSB:0],
				3'h0} +: 8];
		end
	end

	// Power-on flag survives until software has seen it once
	always_ff @(posedge clk) begin
		if (rst) begin
			por <= 1'b1;
		end else if (rd_load && ptr == `TCRB_ADDR_STATUS) begin
			por <= 1'b0;
		end
	end
endmodule : tcrb_device

/* tcrb_host.sv */
// Host controller: AXI4-Lite registers drive serial writes and reads.
// Assumes one attached register bank; no clock stretching on SCL.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "tcrb_params.svh"
module tcrb_host
	import tcrb_pkg::*;
#(
	parameter int         PU_CYC  = (`TCRB_POWERUP_NS + `TCRB_CLK_NS - 1) / `TCRB_CLK_NS,
	parameter int         Q_CYC   = (`TCRB_SCL_PERIOD_NS / 4 + `TCRB_CLK_NS - 1) / `TCRB_CLK_NS,
	parameter logic [4:0] BASE    = `TCRB_I2C_BASE
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	tcrb_link_if.host        link,
	output logic             irq
);
	initial begin
		if (PU_CYC < 1 || PU_CYC > 4095 || Q_CYC < 1 || Q_CYC > 255) begin
			$error("tcrb_host: timing parameter out of range");
		end
	end
	// ****************************************
	// Declarations
	// ****************************************
	// A literal cannot be part-selected; the masks need a named constant
	localparam logic [87:0] ZERO_MASKS = `TCRB_ZERO_MASKS;
	tcrb_host_state_type hs;
	logic [7:0]  aw_a;
	logic [31:0] w_d;
	logic [3:0]  w_s;
	logic        wr_go;
	logic [11:0] pu;
	logic        up;
	logic [7:0]  qc;
	logic [1:0]  q;
	logic        tick;
	logic [2:0]  seq;
	logic [3:0]  bn;
	logic [7:0]  rx;
	logic [7:0]  rd;
	logic        bad;
	logic        failed;
	logic [3:0]  t_reg;
	logic [7:0]  t_dat;
	logic        t_rd;
	logic [1:0]  t_id;
	logic [1:0]  s1;
	logic [1:0]  s2;
	logic        scl_drv;
	logic        sda_drv;
	logic [9:0]  written;
	logic        cmd_wr;
	logic        take;
	logic        fin;
	logic [2:0]  ev;
	logic [2:0]  ist;
	logic [2:0]  ien;
	logic [2:0]  clr;
	logic [2:0]  next_ist;
	logic [7:0]  cb;
	// ****************************************
	// Command checking
	// ****************************************
	function automatic logic cmd_ok(input logic [3:0] r, input logic [7:0] d, input logic rdb);
		logic ok;
		ok = 1'b1;
		if (rdb) begin
			ok = (r <= `TCRB_ADDR_STATUS);
		end else begin
			ok = (r <= `TCRB_LAST_PROG)
				&& ((d & ZERO_MASKS[{r, 3'h0} +: 8]) == 8'h00)
				&& !(r == `TCRB_ADDR_N_HIGH && d[6:0] < `TCRB_N_HIGH_MIN)
				&& !(r == `TCRB_ADDR_R_DIV && d[6:0] < `TCRB_R_MIN);
		end
		return ok;
	endfunction : cmd_ok
	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign wr_go  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	assign cmd_wr = wr_go & (aw_a == `TCRB_OFS_CMD) & (w_s == 4'hF);
	// Refused before power-up settles, while busy, or with a bad value
	assign take = cmd_wr & up & (hs == HOST_IDLE)
		& cmd_ok(w_d[`TCRB_CMD_REG_LSB +: 4], w_d[7:0], w_d[`TCRB_CMD_READ_BIT]);
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `TCRB_RESP_OKAY;
			aw_a          <= 8'h00;
			w_d           <= 32'h0;
			w_s           <= 4'h0;
			ien           <= 3'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_a          <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_d          <= s_axi_wdata;
				w_s          <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_a > `TCRB_OFS_IRQ_CLR || aw_a[1:0] != 2'h0)
					? `TCRB_RESP_SLVERR : `TCRB_RESP_OKAY;
				if (aw_a == `TCRB_OFS_IRQ_EN && w_s[0]) begin
					ien <= w_d[`TCRB_IRQ_W-1:0];
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `TCRB_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `TCRB_RESP_OKAY;
			unique case (s_axi_araddr)
				`TCRB_OFS_STATUS:   s_axi_rdata <= {6'h0, written, rd, 5'h0, &written, up, hs != HOST_IDLE};
				`TCRB_OFS_IRQ_STAT: s_axi_rdata <= {29'h0, ist};
				`TCRB_OFS_IRQ_EN:   s_axi_rdata <= {29'h0, ien};
				`TCRB_OFS_CMD, `TCRB_OFS_IRQ_CLR: s_axi_rdata <= 32'h0;
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `TCRB_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
	// ****************************************
	// Interrupts
	// ****************************************
	assign fin = tick & (hs == HOST_STOP) & (q == 2'h3);
	assign ev  = {cmd_wr & ~take, fin & failed, fin & ~failed};
	assign clr = (wr_go && aw_a == `TCRB_OFS_IRQ_CLR && w_s[0]) ? w_d[2:0] : 3'h0;
	// Set wins over a clear in the same cycle
	assign next_ist = (ist & ~clr) | ev;
	always_ff @(posedge clk) begin
		if (rst) begin
			ist <= 3'h0;
			irq <= 1'b0;
		end else begin
			ist <= next_ist;
			irq <= |(next_ist & ien);
		end
	end
	// ****************************************
	// Power-up wait and programming record
	// ****************************************
	// Device contents are unknown until each byte is written once
	always_ff @(posedge clk) begin
		if (rst) begin
			pu      <= 12'h0;
			written <= 10'h0;
		end else begin
			if (!up) begin
				pu <= 12'(pu + 12'h1);
			end
			if (fin && !failed && !t_rd) begin
				written[t_reg] <= 1'b1;
			end
		end
	end
	assign up = (pu == 12'(PU_CYC));
	// ****************************************
	// Serial master
	// ****************************************
	assign tick = (qc == 8'h0);
	always_ff @(posedge clk) begin
		if (rst || hs == HOST_IDLE || tick) begin
			qc <= 8'(Q_CYC - 1);
		end else begin
			qc <= 8'(qc - 8'h1);
		end
	end
	always_ff @(posedge clk) begin
		s1 <= {link.sda, 1'b0};
		s2 <= s1;
	end
	always_comb begin
		unique case (seq)
			3'h0: cb = {BASE, t_id, 1'b0};
			3'h1: cb = {4'h0, t_reg};
			3'h2: cb = t_dat;
			3'h3: cb = {BASE, t_id, 1'b1};
			default: cb = 8'hFF;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			hs <= HOST_IDLE; q <= 2'h0; seq <= 3'h0; bn <= 4'h0; bad <= 1'b0;
			failed <= 1'b0; rx <= 8'h0; rd <= 8'h0; scl_drv <= 1'b0; sda_drv <= 1'b0;
			t_reg <= 4'h0; t_dat <= 8'h0; t_rd <= 1'b0; t_id <= 2'h0;
		end else if (hs == HOST_IDLE) begin
			q <= 2'h0;
			if (take) begin
				hs     <= HOST_START;
				seq    <= 3'h0;
				failed <= 1'b0;
				t_dat  <= w_d[7:0];
				t_reg  <= w_d[`TCRB_CMD_REG_LSB +: 4];
				t_rd   <= w_d[`TCRB_CMD_READ_BIT];
				t_id   <= w_d[`TCRB_CMD_ID_LSB +: 2];
			end
		end else if (tick) begin
			q <= 2'(q + 2'h1);
			unique case (hs)
				HOST_START: begin
					if (q == 2'h2) sda_drv <= 1'b1;
					if (q == 2'h3) begin scl_drv <= 1'b1; bn <= 4'h0; hs <= HOST_BIT; end
				end
				HOST_RSTART: begin
					if (q == 2'h0) sda_drv <= 1'b0;
					if (q == 2'h1) begin scl_drv <= 1'b0; hs <= HOST_START; end
				end
				HOST_BIT: begin
					if (q == 2'h0) sda_drv <= bn[3] ? 1'b0 : ~cb[~bn[2:0]];
					if (q == 2'h1) scl_drv <= 1'b0;
					if (q == 2'h2 && bn[3]) bad <= s2[1];
					if (q == 2'h2 && !bn[3]) rx <= {rx[6:0], s2[1]};
					if (q == 2'h3) begin
						scl_drv <= 1'b1;
						bn      <= bn[3] ? 4'h0 : 4'(bn + 4'h1);
						if (bn[3]) begin
							if (bad && seq != 3'h4) begin failed <= 1'b1; hs <= HOST_STOP; end
							else if (seq == 3'h1 && t_rd) begin seq <= 3'h3; hs <= HOST_RSTART; end
							else if (seq == 3'h2 || seq == 3'h4) hs <= HOST_STOP;
							else seq <= 3'(seq + 3'h1);
						end
					end
				end
				HOST_STOP: begin
					if (q == 2'h0) sda_drv <= 1'b1;
					if (q == 2'h1) scl_drv <= 1'b0;
					if (q == 2'h2) sda_drv <= 1'b0;
					if (q == 2'h3) begin hs <= HOST_IDLE; if (t_rd && !failed) rd <= rx; end
				end
				default: hs <= HOST_IDLE;
			endcase
		end
	end
	assign link.scl_oe_host = scl_drv;
	assign link.sda_oe_host = sda_drv;
endmodule : tcrb_host

/* tcrb_assertions.sv */
// Checker on the serial link and the bank's decoded outputs.
// Assumes one clock domain, sync reset, and Q_CYC of 8 in the host.
`timescale 1ns/100ps
`include "tcrb_params.svh"
module tcrb_assertions
	import tcrb_pkg::*;
#(
	parameter logic [127:0] ROM_TABLE = `TCRB_ROM_DEFAULT
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        scl_oe_host,
	input wire logic        sda_oe_host,
	input wire logic        sda_oe_dev,
	input wire logic        scl,
	input wire logic        sda,
	input wire logic [14:0] feedback_divider,
	input wire logic [6:0]  reference_divider,
	input wire logic [87:0] reg_image,
	input wire logic [7:0]  rom_table_readback
);
	// ****************************************
	// Helper logic
	// ****************************************
	// Longest legal drive: ack plus an all-zero byte
	int unsigned drive_cnt;
	always_ff @(posedge clk) begin
		if (rst || !sda_oe_dev) begin
			drive_cnt <= 0;
		end else begin
			drive_cnt <= drive_cnt + 1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence fld_rise_s;
		!reg_image[71] ##1 reg_image[71];
	endsequence
	// ****************************************
	// Assertions
	// ****************************************
	fb_div_map_a: assert property (
		feedback_divider == {reg_image[6:0], reg_image[15:8]}) else $error("divider map");
	ref_div_map_a: assert property (
		reference_divider == reg_image[22:16]) else $error("reference map");
	rom_load_a: assert property (
		fld_rise_s |-> rom_table_readback == ROM_TABLE[{reg_image[75:72], 3'b000} +: 8])
		else $error("rom load");
	rom_hold_a: assert property (
		$changed(rom_table_readback) |-> $rose(reg_image[71])) else $error("rom changed");
	img_update_a: assert property (
		$changed(reg_image) |-> !scl) else $error("write off frame");
	dev_data_stable_a: assert property (
		scl && $past(scl) |-> $stable(sda_oe_dev)) else $error("sda moved");
	dev_drive_bound_a: assert property (
		drive_cnt <= 300) else $error("sda held");
	reset_clear_a: assert property (
		$fell(rst) |-> !sda_oe_dev && reg_image == 88'h0 && rom_table_readback == 8'h00)
		else $error("reset state");
endmodule : tcrb_assertions

/* tb_top.sv */
// Bench: drives the host over AXI4-Lite; the host reaches the bank over the link.
// Assumes the interface and both design ends are compiled first.
`timescale 1ns/100ps
`include "tcrb_params.svh"
module tb_top;
	// ****************************************
	// Signals
	// ****************************************
	localparam logic [127:0] ROM_VAL = 128'h00112233445566778899AABBCCDDEEFF;
	localparam logic [87:0]  ZM      = `TCRB_ZERO_MASKS;
	logic        clk = 1'b0, rst = 1'b1, irq, sel_a = 1'b0, sel_b = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rom_rd;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'h0;
	logic [1:0]  bresp, rresp, id;
	logic [2:0]  lock = 3'h0;
	logic [14:0] fb_div;
	logic [6:0]  ref_div;
	logic [87:0] img;
	logic [7:0]  exp_img [0:10];
	int          n_mismatch = 0, checked = 0, cycles = 0, seed;
	always #20 clk = ~clk;
	tcrb_link_if link ();
	tcrb_host #(.PU_CYC(20), .Q_CYC(8)) tcrb_host_inst (.clk(clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .link(link), .irq(irq));
	tcrb_device #(.ROM_TABLE(ROM_VAL)) tcrb_device_inst (.clk(clk), .rst(rst), .link(link),
		.bus_id_select_a(sel_a), .bus_id_select_b(sel_b), .lock_indication(lock),
		.feedback_divider(fb_div), .reference_divider(ref_div), .reg_image(img),
		.rom_table_readback(rom_rd));
	tcrb_assertions #(.ROM_TABLE(ROM_VAL)) tcrb_assertions_inst (.clk(clk), .rst(rst),
		.scl_oe_host(link.scl_oe_host), .sda_oe_host(link.sda_oe_host),
		.sda_oe_dev(link.sda_oe_dev), .scl(link.scl), .sda(link.sda),
		.feedback_divider(fb_div), .reference_divider(ref_div), .reg_image(img),
		.rom_table_readback(rom_rd));
	// ****************************************
	// Tasks
	// ****************************************
	task finish_test;
		if (n_mismatch == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [31:0] mk_cmd(logic [3:0] g, logic [7:0] v, logic rd, logic [1:0] i);
		return {10'h0, i, 3'h0, rd, 4'h0, g, v};
	endfunction : mk_cmd
	task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		r = 2'h3;
		for (int n = 0; n < 100 && r === 2'h3; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
			end
		end
	endtask : axi_write
	task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r = 2'h3;
		for (int n = 0; n < 100 && r === 2'h3; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				r = rresp;
				d = rdata;
				rready <= 1'b0;
			end
		end
	endtask : axi_read
	// Waits on the sticky done, no-answer or refused bits, then clears them
	task do_cmd(input logic [31:0] c, output logic [2:0] st);
		logic [31:0] d;
		logic [1:0]  r;
		axi_write(`TCRB_OFS_CMD, c, r);
		st = 3'h0;
		for (int n = 0; n < 600 && st == 3'h0; n++) begin
			axi_read(`TCRB_OFS_IRQ_STAT, d, r);
			st = d[2:0];
		end
		check(32'(irq), 32'h1);
		axi_write(`TCRB_OFS_IRQ_CLR, 32'h7, r);
	endtask : do_cmd
	task wr(input logic [3:0] g, input logic [7:0] v);
		logic [2:0] st;
		exp_img[g] = v;
		do_cmd(mk_cmd(g, v, 1'b0, id), st);
		check(32'(st), 32'h1);
	endtask : wr
	task rd_reg(input logic [3:0] g, output logic [7:0] b);
		logic [31:0] d;
		logic [1:0]  r;
		logic [2:0]  st;
		do_cmd(mk_cmd(g, 8'h00, 1'b1, id), st);
		check(32'(st), 32'h1);
		axi_read(`TCRB_OFS_STATUS, d, r);
		b = d[15:8];
	endtask : rd_reg
	// ****************************************
	// Sequence
	// ****************************************
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [2:0]  st;
		logic [7:0]  v;
		logic [3:0]  ix;
		seed = 44294;
		for (int g = 0; g < 11; g++) exp_img[g] = 8'h00;
		@(posedge clk);
		sel_a <= 1'($random(seed));
		sel_b <= 1'($random(seed));
		repeat (11) @(posedge clk);
		rst <= 1'b0;
		id = {sel_b, sel_a};
		axi_read(`TCRB_OFS_STATUS, d, r);
		check(d & 32'h03FF0007, 32'h0);
		// Too early: refused, flagged but masked
		axi_write(`TCRB_OFS_CMD, mk_cmd(4'h0, 8'h01, 1'b0, id), r);
		axi_read(`TCRB_OFS_IRQ_STAT, d, r);
		check(d, 32'h4);
		check(32'(irq), 32'h0);
		axi_write(`TCRB_OFS_IRQ_EN, 32'h7, r);
		axi_read(`TCRB_OFS_IRQ_EN, d, r);
		check(d, 32'h7);
		check(32'(irq), 32'h1);
		axi_write(`TCRB_OFS_IRQ_CLR, 32'h4, r);
		axi_read(`TCRB_OFS_IRQ_CLR, d, r);
		check(d, 32'h0);
		check(32'(irq), 32'h0);
		d = 32'h0;
		for (int n = 0; n < 50 && d[1] !== 1'b1; n++) axi_read(`TCRB_OFS_STATUS, d, r);
		axi_read(8'h40, d, r);
		check(32'(r), 32'h2);
		check(d, 32'h0);
		axi_write(8'h14, 32'h0, r);
		check(32'(r), 32'h2);
		axi_write(8'h06, 32'h0, r);
		check(32'(r), 32'h2);
		do_cmd(mk_cmd(4'h1, 8'h55, 1'b0, ~id), st);
		check(32'(st), 32'h2);
		check(32'(img[15:8]), 32'h0);
		// Pass 0 sets the lowest legal dividers, pass 1 random values
		for (int p = 0; p < 2; p++) begin
			for (int g = 0; g < 10; g++) begin
				v = p ? 8'($random(seed)) & ~ZM[8*g+:8] : 8'h00;
				if (g == 0) v = v | 8'h01;
				if (g == 2) v = v | 8'h10;
				if (g == 8) v[7] = 1'b0;
				wr(4'(g), v);
			end
			for (int g = 0; g < 11; g++) check(32'(img[8*g+:8]), 32'(exp_img[g]));
			check(32'(fb_div), {17'h0, exp_img[0][6:0], exp_img[1]});
			check(32'(ref_div), {25'h0, exp_img[2][6:0]});
		end
		axi_read(`TCRB_OFS_STATUS, d, r);
		check(d & 32'h03FF0004, 32'h03FF0004);
		ix = 4'($random(seed));
		wr(4'h9, {4'h0, ix});
		wr(4'h8, 8'h80);
		check(32'(rom_rd), 32'(ROM_VAL[8*ix+:8]));
		wr(4'h9, {4'h0, ix ^ 4'h5});
		wr(4'h8, 8'h80);
		check(32'(rom_rd), 32'(ROM_VAL[8*ix+:8]));
		wr(4'h8, 8'h00);
		wr(4'h8, 8'h80);
		ix = ix ^ 4'h5;
		check(32'(rom_rd), 32'(ROM_VAL[8*ix+:8]));
		do_cmd(mk_cmd(4'hB, 8'hFF, 1'b0, id), st);
		check(32'(st), 32'h4);
		check(32'(rom_rd), 32'(ROM_VAL[8*ix+:8]));
		// Status twice: the first read returns the power-on flag and clears it; the second sees it low
		lock <= 3'($random(seed));
		rd_reg(4'hC, v);
		check(32'(v & 8'hF0), {24'h0, 1'b1, lock, 4'h0});
		rd_reg(4'hC, v);
		check(32'(v & 8'hF0), {24'h0, 1'b0, lock, 4'h0});
		rd_reg(4'hB, v);
		check(32'(v), 32'(ROM_VAL[8*ix+:8]));
		ix = 4'($unsigned($random(seed)) % 10);
		rd_reg(ix, v);
		check(32'(v), 32'(exp_img[ix]));
		finish_test();
	end
endmodule : tb_top
